// ===== dv/soc_host_model.sv
// host side of the link: serial clock, chip select and lane capture
`timescale 1ns/100ps
module soc_host_model
(
	input  wire logic       go,
	input  wire logic [5:0] nbits,
	input  wire logic       dual,
	input  wire logic       lane0,
	input  wire logic       lane1,
	input  wire logic       tmode,
	input  wire logic       tclk,
	output logic            sclk,
	output logic            cs_n,
	output logic            done,
	output logic [31:0]     cap
);
	initial
	begin
		sclk = 1'b0;
		cs_n = 1'b1;
		done = 1'b0;
		cap = 32'h0;
	end
	// with sclk (tmode low): samples just before the fall, ahead of the device's launch lag
	always @(posedge go)
	begin
		done = 1'b0;
		cap = 32'h0;
		cs_n = 1'b0;
		if (tmode)
		begin
			// device clock: data moves on its fall, so take it just after the rise
			repeat (nbits)
			begin
				@(posedge tclk);
				#5;
				cap = {cap[30:0], lane0};
			end
		end
		else
		begin
			#200;
			repeat (dual ? nbits / 2 : nbits)
			begin
				sclk = 1'b1;
				#80;
				// first lane carries the earlier bit of each pair
				if (dual)
					cap = {cap[29:0], lane0, lane1};
				else
					cap = {cap[30:0], lane0};
				sclk = 1'b0;
				#80;
			end
		end
		#100;
		cs_n = 1'b1;
		#200;
		done = 1'b1;
	end
endmodule

// ===== dv/soc_serial_out_config_bench.sv
// self-checking bench for the serial output configuration block
`timescale 1ns/100ps
`include "soc_serial_out_regs.vh"
module soc_serial_out_config_bench;
	logic        clock, rst_n, app_rst_n, reg_wr, reg_rd, alarm_active, go, dual, rd_d, tmode;
	logic [1:0]  spi_mode;
	logic [7:0]  reg_addr, reg_wdata, d;
	logic [17:0] conv_data;
	logic [3:0]  device_addr, range_setting, flags;
	logic [5:0]  nbits;
	logic [31:0] e;
	logic [31:0] exp_q[$];
	wire  [7:0]  reg_rdata;
	wire  [31:0] cap;
	wire         sclk, cs_n, done, lane0, lane1, oe1_n, tclk;
	int          error_cnt = 0;
	int          checks = 0;
	logic [7:0]  adr[9] = '{8'h0c, 8'h0d, 8'h10, 8'h11, 8'h0e, 8'h0f, 8'h12, 8'h13, 8'h20};
	logic [7:0]  msk[9] = '{8'h43, 8'h13, 8'h0f, 8'h7d, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0]  role[4] = '{8'h00, 8'h01, 8'h12, 8'h02};
	logic [31:0] tab[12] = '{32'h12, 32'h40012, 32'h50012, 32'h60012, 32'h70012, 32'h80014,
		32'h4016, 32'h116, 32'h3014, 32'h413, 32'h03000012, 32'h40000012};
	soc_serial_out_config DUT (.clock(clock), .rst_n(rst_n), .app_rst_n(app_rst_n),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .spi_in_mode(spi_mode), .conv_data(conv_data),
		.device_addr(device_addr), .range_setting(range_setting), .supply_alarm_hi(flags[3]),
		.supply_alarm_lo(flags[2]), .input_alarm_hi(flags[1]), .input_alarm_lo(flags[0]),
		.alarm_active(alarm_active), .sclk(sclk), .cs_n(cs_n), .first_lane_out(lane0),
		.first_lane_oe_n(), .second_lane_out(lane1), .second_lane_oe_n(oe1_n),
		.transmit_clock_source_out(tclk));
	soc_host_model u_host (.go(go), .nbits(nbits), .dual(dual), .lane0(lane0), .lane1(lane1),
		.tmode(tmode), .tclk(tclk), .sclk(sclk), .cs_n(cs_n), .done(done), .cap(cap));
	task automatic check(input string what, input logic [31:0] ex, input logic [31:0] got);
		checks++;
		if (got !== ex)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, ex, got);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge clock);
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		@(negedge clock);
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] v);
		@(negedge clock);
		reg_addr = a;
		reg_rd = 1'b1;
		exp_q.push_back({24'h0, v});
		@(negedge clock);
		reg_rd = 1'b0;
	endtask
	task automatic frame(input logic [5:0] n, input logic dl, input logic [31:0] v);
		@(negedge clock);
		nbits = n;
		dual = dl;
		go = 1'b1;
		exp_q.push_back(v);
		@(negedge clock);
		go = 1'b0;
		@(posedge done);
		repeat (4) @(negedge clock);
	endtask
	always @(posedge clock)
		rd_d <= reg_rd;
	always @(negedge clock)
		if (rd_d === 1'b1)
			check("reg_rdata", exp_q.pop_front(), {24'h0, reg_rdata});
	always @(posedge done)
		check("frame", exp_q.pop_front(), cap);
	initial
	begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	initial
	begin
		#300000;
		error_cnt++;
		end_of_test();
	end
	initial
	begin
		{reg_addr, reg_wdata, conv_data, device_addr, range_setting, flags, nbits, spi_mode} = '0;
		{reg_wr, reg_rd, go, dual, alarm_active, rst_n, tmode} = '0;
		app_rst_n = 1'b1;
		void'($urandom(71096));
		repeat (6) @(negedge clock);
		rst_n = 1'b1;
		for (int i = 0; i < 9; i++)
			rd(adr[i], 8'h00);
		$display("test reset values done");
		for (int i = 0; i < 9; i++)
		begin
			d = 8'($urandom);
			if (i == 0 && d[1:0] == 2'b10)
				d[0] = 1'b1;
			wr(adr[i], d);
			rd(adr[i], d & msk[i]);
		end
		$display("test readback done");
		for (int i = 0; i < 4; i++)
			wr(adr[i], 8'hff);
		app_rst_n = 1'b0;
		@(negedge clock);
		app_rst_n = 1'b1;
		rd(8'h0c, 8'h43);
		rd(8'h0d, 8'h00);
		rd(8'h10, 8'h08);
		rd(8'h11, 8'h00);
		rst_n = 1'b0;
		@(negedge clock);
		rst_n = 1'b1;
		rd(8'h0c, 8'h00);
		$display("test resets done");
		alarm_active = 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			wr(8'h0d, role[i]);
			repeat (3) @(negedge clock);
			check("second_lane_oe_n", i == 0, oe1_n);
			if (i != 0)
				check("second_lane_out", i != 3, lane1);
		end
		$display("test second lane done");
		for (int i = 0; i < 12; i++)
		begin
			wr(8'h0c, tab[i][31:24]);
			wr(8'h10, tab[i][23:16]);
			wr(8'h11, tab[i][15:8]);
			{conv_data, device_addr, range_setting, flags} = 30'($urandom);
			case (i)
				1: e = 32'h0;
				2: e = 32'h3ffff;
				3: e = `SOC_PAT_ALT1;
				4: e = `SOC_PAT_ALT2;
				5: e = {conv_data, ^conv_data, 1'b0};
				6: e = {conv_data, device_addr};
				7: e = {conv_data, range_setting};
				8: e = {conv_data, flags[3:2]};
				9: e = {conv_data, flags[1]};
				default: e = conv_data;
			endcase
			frame(tab[i][5:0], 1'b0, e);
		end
		spi_mode = 2'b01;
		conv_data = 18'($urandom);
		frame(6'd18, 1'b0, conv_data);
		spi_mode = 2'b00;
		wr(8'h0c, 8'h43);
		tmode = 1'b1;
		conv_data = 18'($urandom);
		frame(6'd18, 1'b0, conv_data);
		tmode = 1'b0;
		wr(8'h0c, 8'h00);
		wr(8'h0d, 8'h03);
		conv_data = 18'($urandom);
		frame(6'd18, 1'b1, conv_data);
		$display("test frames done");
		end_of_test();
	end
endmodule

// ===== dv/soc_serial_out_config_checker.sv
// port assertions for the serial output configuration block
`timescale 1ns/100ps
module soc_serial_out_config_checker
(
	input wire       clock,
	input wire       rst_n,
	input wire [7:0] reg_addr,
	input wire       reg_rd,
	input wire [7:0] reg_rdata,
	input wire       cs_n,
	input wire       first_lane_oe_n,
	input wire       second_lane_oe_n,
	input wire       transmit_clock_source_out
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	wire mapped = reg_addr == 8'h0c || reg_addr == 8'h0d || reg_addr == 8'h10 || reg_addr == 8'h11;
	a_unmapped_zero: assert property (reg_rd && !mapped |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_ctl_lo_rsvd: assert property (reg_rd && reg_addr == 8'h0c |=> !(reg_rdata & 8'hbc))
		else $error("control byte 0 reserved bits set");
	a_ctl_hi_rsvd: assert property (reg_rd && reg_addr == 8'h0d |=> !(reg_rdata & 8'hec))
		else $error("control byte 1 reserved bits set");
	a_word_lo_rsvd: assert property (reg_rd && reg_addr == 8'h10 |=> !(reg_rdata & 8'hf0))
		else $error("word byte 0 reserved bits set");
	a_word_hi_rsvd: assert property (reg_rd && reg_addr == 8'h11 |=> !(reg_rdata & 8'h82))
		else $error("word byte 1 reserved bits set");
	a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without read");
	a_idle_hiz: assert property (cs_n [*5] |-> first_lane_oe_n)
		else $error("lane driven outside frame");
	a_idle_clk: assert property (cs_n [*5] |-> !transmit_clock_source_out)
		else $error("transmit clock outside frame");
	a_frame_drive: assert property ($fell(cs_n) ##0 !cs_n [*6] |-> !first_lane_oe_n)
		else $error("lane not driven in frame");
	a_reset_quiet: assert property ($rose(rst_n) |-> !reg_rdata && first_lane_oe_n
		&& second_lane_oe_n)
		else $error("outputs not quiet after reset");
	c_frame: cover property ($fell(first_lane_oe_n));
	c_lane2: cover property ($fell(second_lane_oe_n));
	c_ssync: cover property ($rose(transmit_clock_source_out));
endmodule
bind soc_serial_out_config soc_serial_out_config_checker u_chk (.clock, .rst_n, .reg_addr,
	.reg_rd, .reg_rdata, .cs_n, .first_lane_oe_n, .second_lane_oe_n, .transmit_clock_source_out);

// ===== rtl/soc_serial_out_config.v
// serial output control registers, second lane muxing and output frame shifter
`timescale 1ns/100ps
`include "soc_serial_out_regs.vh"
module soc_serial_out_config
(
	clock,
	rst_n,
	app_rst_n,
	reg_addr,
	reg_wr,
	reg_wdata,
	reg_rd,
	reg_rdata,
	spi_in_mode,
	conv_data,
	device_addr,
	range_setting,
	supply_alarm_hi,
	supply_alarm_lo,
	input_alarm_hi,
	input_alarm_lo,
	alarm_active,
	sclk,
	cs_n,
	first_lane_out,
	first_lane_oe_n,
	second_lane_out,
	second_lane_oe_n,
	transmit_clock_source_out
);
	input  wire        clock;
	input  wire        rst_n;
	input  wire        app_rst_n;
	input  wire [7:0]  reg_addr;
	input  wire        reg_wr;
	input  wire [7:0]  reg_wdata;
	input  wire        reg_rd;
	output reg  [7:0]  reg_rdata;
	input  wire [1:0]  spi_in_mode;
	input  wire [17:0] conv_data;
	input  wire [3:0]  device_addr;
	input  wire [3:0]  range_setting;
	input  wire        supply_alarm_hi;
	input  wire        supply_alarm_lo;
	input  wire        input_alarm_hi;
	input  wire        input_alarm_lo;
	input  wire        alarm_active;
	input  wire        sclk;
	input  wire        cs_n;
	output wire        first_lane_out;
	output reg         first_lane_oe_n;
	output reg         second_lane_out;
	output reg         second_lane_oe_n;
	output reg         transmit_clock_source_out;

	// power-on class fields
	reg [1:0]  proto_ff;
	reg        tclk_ff;
	reg        par_ff;
	// application class fields
	reg        gpo_ff;
	reg [1:0]  role_ff;
	reg        addr_inc_ff;
	reg [1:0]  sup_inc_ff;
	reg [1:0]  in_inc_ff;
	reg        rng_inc_ff;
	reg [2:0]  dval_ff;

	reg [1:0]  sclk_sync_ff;
	reg [1:0]  cs_sync_ff;
	reg        sclk_prev_ff;
	reg        cs_prev_ff;
	reg [31:0] sr_ff;
	reg [5:0]  cnt_ff;
	reg        skip_ff;
	reg        busy_ff;

	reg [31:0] nxt_sr;
	reg [5:0]  nxt_cnt;
	reg        nxt_skip;
	reg        nxt_busy;
	reg        nxt_clk_out;
	reg        nxt_second_out;
	reg        nxt_second_oe_n;

	wire [31:0] sout_img;
	wire [31:0] word_img;
	reg  [31:0] sout_wimg;
	reg  [31:0] word_wimg;
	wire        hit_sout;
	wire        hit_word;
	wire [31:0] frame_word;
	wire [5:0]  frame_len;

	// only defined fields enter the images, so reserved bits read zero
	assign sout_img = {16'h0000, 3'b000, gpo_ff, 2'b00, role_ff, 1'b0, tclk_ff,
		4'b0000, proto_ff};
	assign word_img = {16'h0000, 1'b0, addr_inc_ff, sup_inc_ff, in_inc_ff, 1'b0,
		rng_inc_ff, 4'b0000, par_ff, dval_ff};
	assign hit_sout = (reg_addr[7:2] == `SOC_SOUT_CTL_WORD);
	assign hit_word = (reg_addr[7:2] == `SOC_WORD_CTL_WORD);

	// byte merge, least significant byte at the lowest address
	always @*
	begin
		sout_wimg = sout_img;
		word_wimg = word_img;
		case (reg_addr[1:0])
			2'd0:
			begin
				sout_wimg[7:0] = reg_wdata;
				word_wimg[7:0] = reg_wdata;
			end
			2'd1:
			begin
				sout_wimg[15:8] = reg_wdata;
				word_wimg[15:8] = reg_wdata;
			end
			2'd2:
			begin
				sout_wimg[23:16] = reg_wdata;
				word_wimg[23:16] = reg_wdata;
			end
			default:
			begin
				sout_wimg[31:24] = reg_wdata;
				word_wimg[31:24] = reg_wdata;
			end
		endcase
	end

	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			proto_ff <= `SOC_RST_PROTO;
			tclk_ff  <= `SOC_RST_BIT;
			par_ff   <= `SOC_RST_BIT;
		end
		else if (reg_wr && hit_sout)
		begin
			proto_ff <= sout_wimg[`SOC_PROTO_LSB+1:`SOC_PROTO_LSB];
			tclk_ff  <= sout_wimg[`SOC_TCLK_BIT];
		end
		else if (reg_wr && hit_word)
		begin
			par_ff <= word_wimg[`SOC_PAR_BIT];
		end
	end

	// reserved positions are never copied out of the merged image
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			gpo_ff      <= `SOC_RST_BIT;
			role_ff     <= `SOC_RST_ROLE;
			addr_inc_ff <= `SOC_RST_BIT;
			sup_inc_ff  <= `SOC_RST_INC2;
			in_inc_ff   <= `SOC_RST_INC2;
			rng_inc_ff  <= `SOC_RST_BIT;
			dval_ff     <= `SOC_RST_DVAL;
		end
		else if (!app_rst_n)
		begin
			gpo_ff      <= `SOC_RST_BIT;
			role_ff     <= `SOC_RST_ROLE;
			addr_inc_ff <= `SOC_RST_BIT;
			sup_inc_ff  <= `SOC_RST_INC2;
			in_inc_ff   <= `SOC_RST_INC2;
			rng_inc_ff  <= `SOC_RST_BIT;
			dval_ff     <= `SOC_RST_DVAL;
		end
		else if (reg_wr && hit_sout)
		begin
			gpo_ff  <= sout_wimg[`SOC_GPO_BIT];
			role_ff <= sout_wimg[`SOC_ROLE_LSB+1:`SOC_ROLE_LSB];
		end
		else if (reg_wr && hit_word)
		begin
			addr_inc_ff <= word_wimg[`SOC_ADDR_INC_BIT];
			sup_inc_ff  <= word_wimg[`SOC_SUP_INC_LSB+1:`SOC_SUP_INC_LSB];
			in_inc_ff   <= word_wimg[`SOC_IN_INC_LSB+1:`SOC_IN_INC_LSB];
			rng_inc_ff  <= word_wimg[`SOC_RNG_INC_BIT];
			dval_ff     <= word_wimg[`SOC_DVAL_LSB+2:`SOC_DVAL_LSB];
		end
	end

	// unmapped addresses read zero
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata <= 8'h00;
		else if (reg_rd)
		begin
			if (hit_sout)
				reg_rdata <= sout_img[{reg_addr[1:0], 3'b000} +: 8];
			else if (hit_word)
				reg_rdata <= word_img[{reg_addr[1:0], 3'b000} +: 8];
			else
				reg_rdata <= 8'h00;
		end
	end

	soc_word_build u_word_build
	(
		.conv_data            (conv_data),
		.data_value_select    (dval_ff),
		.parity_enable        (par_ff),
		.address_tag_include  (addr_inc_ff),
		.range_tag_include    (rng_inc_ff),
		.supply_alarm_include (sup_inc_ff),
		.input_alarm_include  (in_inc_ff),
		.device_addr          (device_addr),
		.range_setting        (range_setting),
		.supply_alarm_hi      (supply_alarm_hi),
		.supply_alarm_lo      (supply_alarm_lo),
		.input_alarm_hi       (input_alarm_hi),
		.input_alarm_lo       (input_alarm_lo),
		.frame_word           (frame_word),
		.frame_len            (frame_len)
	);

	// pins come from the host's domain: two stages before any use
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sclk_sync_ff <= 2'b00;
			cs_sync_ff   <= 2'b11;
			sclk_prev_ff <= 1'b0;
			cs_prev_ff   <= 1'b1;
		end
		else
		begin
			sclk_sync_ff <= {sclk_sync_ff[0], sclk};
			cs_sync_ff   <= {cs_sync_ff[0], cs_n};
			sclk_prev_ff <= sclk_sync_ff[1];
			cs_prev_ff   <= cs_sync_ff[1];
		end
	end

	wire sclk_rise = sclk_sync_ff[1] & ~sclk_prev_ff;
	wire sclk_fall = ~sclk_sync_ff[1] & sclk_prev_ff;
	wire cs_fall   = ~cs_sync_ff[1] & cs_prev_ff;
	wire cs_rise   = cs_sync_ff[1] & ~cs_prev_ff;
	wire ssync     = (proto_ff == `SOC_PROTO_SSYNC);
	// clock source matters only in source-synchronous mode
	wire int_clk   = ssync & tclk_ff;
	wire dual      = (role_ff == `SOC_ROLE_DUAL);
	wire cpha      = spi_in_mode[0];
	// launch edge is rising when polarity and phase differ
	wire spi_launch = (spi_in_mode[1] ^ spi_in_mode[0]) ? sclk_rise : sclk_fall;
	wire launch_int = busy_ff & transmit_clock_source_out;
	reg  launch;

	always @*
	begin
		nxt_sr      = sr_ff;
		nxt_cnt     = cnt_ff;
		nxt_skip    = skip_ff;
		nxt_busy    = busy_ff;
		nxt_clk_out = 1'b0;
		launch      = 1'b0;
		if (ssync)
		begin
			if (int_clk)
			begin
				// a flop cannot emit the full rate, so one launch per two cycles
				nxt_clk_out = busy_ff & (cnt_ff != 6'd0) & ~transmit_clock_source_out;
				launch = launch_int;
			end
			else
			begin
				nxt_clk_out = busy_ff & sclk_sync_ff[1];
				launch = sclk_fall;
			end
		end
		else
			launch = spi_launch;
		if (cs_fall)
		begin
			nxt_sr   = frame_word;
			nxt_cnt  = frame_len;
			nxt_skip = ~ssync & cpha;
			nxt_busy = 1'b1;
		end
		else if (cs_rise)
		begin
			nxt_sr   = 32'h00000000;
			nxt_cnt  = 6'd0;
			nxt_skip = 1'b0;
			nxt_busy = 1'b0;
		end
		else if (busy_ff && launch && cnt_ff != 6'd0)
		begin
			if (skip_ff)
				nxt_skip = 1'b0;
			else if (dual)
			begin
				nxt_sr  = {sr_ff[29:0], 2'b00};
				nxt_cnt = (cnt_ff > 6'd2) ? cnt_ff - 6'd2 : 6'd0;
			end
			else
			begin
				nxt_sr  = {sr_ff[30:0], 1'b0};
				nxt_cnt = cnt_ff - 6'd1;
			end
		end
	end

	// second pin role mux
	always @*
	begin
		case (role_ff)
			`SOC_ROLE_HIZ:
			begin
				nxt_second_out  = 1'b0;
				nxt_second_oe_n = 1'b1;
			end
			`SOC_ROLE_ALARM:
			begin
				nxt_second_out  = alarm_active;
				nxt_second_oe_n = 1'b0;
			end
			`SOC_ROLE_GPO:
			begin
				nxt_second_out  = gpo_ff;
				nxt_second_oe_n = 1'b0;
			end
			`SOC_ROLE_DUAL:
			begin
				nxt_second_out  = nxt_sr[30];
				nxt_second_oe_n = ~nxt_busy;
			end
			default:
			begin
				nxt_second_out  = 1'b0;
				nxt_second_oe_n = 1'b1;
			end
		endcase
	end

	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sr_ff            <= 32'h00000000;
			cnt_ff           <= 6'd0;
			skip_ff          <= 1'b0;
			busy_ff          <= 1'b0;
			transmit_clock_source_out    <= 1'b0;
			first_lane_oe_n  <= 1'b1;
			second_lane_out  <= 1'b0;
			second_lane_oe_n <= 1'b1;
		end
		else
		begin
			sr_ff            <= nxt_sr;
			cnt_ff           <= nxt_cnt;
			skip_ff          <= nxt_skip;
			busy_ff          <= nxt_busy;
			transmit_clock_source_out    <= nxt_clk_out;
			first_lane_oe_n  <= ~nxt_busy;
			second_lane_out  <= nxt_second_out;
			second_lane_oe_n <= nxt_second_oe_n;
		end
	end

	assign first_lane_out = sr_ff[31];
endmodule

// ===== rtl/soc_serial_out_regs.vh
// offsets, field positions, reset values and patterns of the serial output configuration block
`ifndef SOC_SERIAL_OUT_REGS_VH
`define SOC_SERIAL_OUT_REGS_VH

`define SOC_SOUT_CTL_WORD     6'h03
`define SOC_WORD_CTL_WORD     6'h04
`define SOC_SOUT_CTL_BYTE0    8'h0c
`define SOC_WORD_CTL_BYTE0    8'h10

`define SOC_PROTO_LSB         0
`define SOC_TCLK_BIT          6
`define SOC_ROLE_LSB          8
`define SOC_GPO_BIT           12

`define SOC_DVAL_LSB          0
`define SOC_PAR_BIT           3
`define SOC_RNG_INC_BIT       8
`define SOC_IN_INC_LSB        10
`define SOC_SUP_INC_LSB       12
`define SOC_ADDR_INC_BIT      14

`define SOC_PROTO_SSYNC       2'b11
`define SOC_ROLE_HIZ          2'b00
`define SOC_ROLE_ALARM        2'b01
`define SOC_ROLE_GPO          2'b10
`define SOC_ROLE_DUAL         2'b11

`define SOC_RST_PROTO         2'b00
`define SOC_RST_ROLE          2'b00
`define SOC_RST_INC2          2'b00
`define SOC_RST_DVAL          3'b000
`define SOC_RST_BIT           1'b0

`define SOC_DVAL_ZEROS        3'b100
`define SOC_DVAL_ONES         3'b101
`define SOC_DVAL_ALT1         3'b110
`define SOC_DVAL_ALT2         3'b111
`define SOC_PAT_ALT1          18'h15555
`define SOC_PAT_ALT2          18'h0cccc

`define SOC_FRAME_W           32
`define SOC_CONV_W            18

`endif

// ===== rtl/soc_word_build.v
// assembles the left-justified output frame and its bit count
`timescale 1ns/100ps
`include "soc_serial_out_regs.vh"
module soc_word_build
(
	conv_data,
	data_value_select,
	parity_enable,
	address_tag_include,
	range_tag_include,
	supply_alarm_include,
	input_alarm_include,
	device_addr,
	range_setting,
	supply_alarm_hi,
	supply_alarm_lo,
	input_alarm_hi,
	input_alarm_lo,
	frame_word,
	frame_len
);
	input  wire [17:0] conv_data;
	input  wire [2:0]  data_value_select;
	input  wire        parity_enable;
	input  wire        address_tag_include;
	input  wire        range_tag_include;
	input  wire [1:0]  supply_alarm_include;
	input  wire [1:0]  input_alarm_include;
	input  wire [3:0]  device_addr;
	input  wire [3:0]  range_setting;
	input  wire        supply_alarm_hi;
	input  wire        supply_alarm_lo;
	input  wire        input_alarm_hi;
	input  wire        input_alarm_lo;
	output reg  [31:0] frame_word;
	output reg  [5:0]  frame_len;

	reg [17:0] val;
	reg [31:0] acc;
	reg [5:0]  n;
	reg        p_conv;
	reg        p_frame;

	always @*
	begin
		val = conv_data;
		case (data_value_select)
			`SOC_DVAL_ZEROS: val = 18'h00000;
			`SOC_DVAL_ONES:  val = 18'h3ffff;
			`SOC_DVAL_ALT1:  val = `SOC_PAT_ALT1;
			`SOC_DVAL_ALT2:  val = `SOC_PAT_ALT2;
			default:         val = conv_data;
		endcase
		acc = {14'h0000, val};
		n = 6'd18;
		if (address_tag_include)
		begin
			acc = {acc[27:0], device_addr};
			n = n + 6'd4;
		end
		// order inside each alarm pair: high flag first
		if (supply_alarm_include[0])
		begin
			acc = {acc[30:0], supply_alarm_hi};
			n = n + 6'd1;
		end
		if (supply_alarm_include[1])
		begin
			acc = {acc[30:0], supply_alarm_lo};
			n = n + 6'd1;
		end
		if (input_alarm_include[0])
		begin
			acc = {acc[30:0], input_alarm_hi};
			n = n + 6'd1;
		end
		if (input_alarm_include[1])
		begin
			acc = {acc[30:0], input_alarm_lo};
			n = n + 6'd1;
		end
		if (range_tag_include)
		begin
			acc = {acc[27:0], range_setting};
			n = n + 6'd4;
		end
		p_conv = ^val;
		p_frame = ^acc ^ p_conv;
		if (parity_enable)
		begin
			acc = {acc[29:0], p_conv, p_frame};
			n = n + 6'd2;
		end
		frame_word = acc << (6'd32 - n);
		frame_len = n;
	end
endmodule
